// *** common/ccmc_pkg.sv ***
// Shared constants and bus carrier types for the channel mode control block.
package ccmc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int             ADDR_W          = 12;
	localparam logic [11:0]    MODE_REG_OFFSET = 12'h018;
	localparam logic [15:0]    MODE_REG_RESET  = 16'h0000;
	localparam logic [15:0]    RSVD_READ       = 16'h0000;

	// ----------------------------------------------------------------
	// Field positions inside one 8-bit channel slice
	// ----------------------------------------------------------------
	localparam int CH_STRIDE = 8;
	localparam int SEL_LSB   = 0;
	localparam int FE_BIT    = 2;
	localparam int PSC_LSB   = 2;
	localparam int PE_BIT    = 3;
	localparam int FLT_LSB   = 4;
	localparam int MODE_LSB  = 4;
	localparam int CE_BIT    = 7;

	// ----------------------------------------------------------------
	// Direction select and output mode codes
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_OUTPUT = 2'h0;
	localparam logic [1:0] SEL_OWN    = 2'h1;
	localparam logic [1:0] SEL_NEIGH  = 2'h2;
	localparam logic [1:0] SEL_TRIG   = 2'h3;
	localparam logic [2:0] OM_FROZEN  = 3'h0;
	localparam logic [2:0] OM_SET     = 3'h1;
	localparam logic [2:0] OM_CLEAR   = 3'h2;
	localparam logic [2:0] OM_TOGGLE  = 3'h3;
	localparam logic [2:0] OM_LOW     = 3'h4;
	localparam logic [2:0] OM_HIGH    = 3'h5;
	localparam logic [2:0] OM_PWM1    = 3'h6;
	localparam logic [2:0] OM_PWM2    = 3'h7;

	// ----------------------------------------------------------------
	// Timing and filter constants
	// ----------------------------------------------------------------
	localparam int         FAST_DELAY_CYC = 3;
	localparam int         TRIG_PIPE_LEN  = FAST_DELAY_CYC - 1;
	localparam logic [2:0] RATE_KERNEL    = 3'h7;
	localparam int         DTS_DIV_W      = 5;

	// ----------------------------------------------------------------
	// Bus carrier types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_ACK  = 2'b10
	} ccmc_apb_st_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} ccmc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ccmc_apb_rsp_t;

endpackage : ccmc_pkg

// *** design/ccmc_channel_mode.sv ***
// Mode control, input filter, capture prescaler and output reference for two timer channels.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Select 00 makes an output, 01 own input, 10 neighbour input.
// - Select 11 takes the internal trigger, only while an internal trigger is chosen.
// - Select bits are writable only while the channel enable is low.
// - Filter passes a new level after N agreeing samples.
// - Filter code 0 is unfiltered at the dead-time rate; 1..3 use kernel clock, N 2/4/8.
// - Codes 4..15 sample dead-time clock divided by 2..32 with the tabled N.
// - Prescaler captures every edge, or once every 2, 4 or 8 events.
// - Prescaler count is cleared while the channel enable is low.
// - Clear enable drives the reference low while the external trigger is high.
// - Frozen holds; 001 sets, 010 clears, 011 toggles on a match.
// - Mode 100 holds the reference low, 101 holds it high.
// - PWM 1: high while counter below compare up, low while above down.
// - PWM 2 is the inverse of PWM 1.
// - Mode and preload ignore writes under lock 3 on an output channel.
// - PWM reference moves only on a comparison change, leaving frozen, a fast trigger or a clear.
// - Preload off writes compare at once; on, shadow loads at update.
// - Fast enable turns a trigger edge into a match after 3 cycles.
// - Fast enable acts only in the two PWM modes.
// - Channel 1 fields sit in bits 7 to 0.
// - Channel 2 repeats the layout in bits 15 to 8.
// - An input channel captures only while its enable is high.
module ccmc_channel_mode
	import ccmc_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic                       core_clk,     // Kernel clock.
	input  wire logic                       nrst,         // Synchronous reset, active low.
	input  wire logic                       clkEn,        // Freezes all state while low.
	input  wire ccmc_apb_req_t              apbReq,       // APB request from the master.
	output var  ccmc_apb_rsp_t              apbRsp,       // APB answer, registered.
	input  wire logic [1:0]                 timerIn,      // Timer inputs one and two.
	input  wire logic                       trigSrc,      // Internal trigger source level.
	input  wire logic                       trigInternal, // Trigger select names an internal input.
	input  wire logic                       etrFiltered,  // Filtered external trigger.
	input  wire logic                       trigEdge,     // Active trigger edge, one cycle.
	input  wire logic [1:0]                 chEnable,     // Channel enable bits.
	input  wire logic                       lockLevel3,   // Protection lock level 3 is set.
	input  wire logic                       dtsTick,      // Dead-time sample clock enable.
	input  wire logic [CNT_W-1:0]           counterVal,   // Timer counter.
	input  wire logic                       countDown,    // Counter runs downwards.
	input  wire logic                       updateEvt,    // Update event, one cycle.
	input  wire logic [1:0]                 cmpWr,        // Compare register write strobes.
	input  wire logic [CNT_W-1:0]           cmpWdata,     // Compare write data.
	output logic      [1:0]                 outRef,       // Output reference levels.
	output logic      [1:0]                 capStrobe,    // Capture command, one cycle.
	output logic      [1:0]                 inputLevel,   // Filtered channel inputs.
	output logic      [1:0][CNT_W-1:0]      activeCmp     // Active compare values.
);

	// ----------------------------------------------------------------
	// Parameter check and state layout
	// ----------------------------------------------------------------
	if (CNT_W < 2 || CNT_W > 32) begin : g_chk
		$error("CNT_W must lie between 2 and 32");
	end

	typedef struct packed {
		ccmc_apb_st_t                  apb;
		ccmc_apb_rsp_t                 rsp;
		logic [15:0]                   mode;
		logic [DTS_DIV_W-1:0]          dtsDiv;
		logic [1:0]                    filt;
		logic [1:0][2:0]               fcnt;
		logic [1:0][2:0]               psc;
		logic [1:0]                    cap;
		logic [1:0]                    oref;
		logic [1:0]                    pwmPrev;
		logic [1:0]                    matchPrev;
		logic [1:0][2:0]               modePrev;
		logic [TRIG_PIPE_LEN-1:0]      trigPipe;
		logic [1:0][CNT_W-1:0]         cmpAct;
		logic [1:0][CNT_W-1:0]         cmpShadow;
	} ccmc_state_t;

	ccmc_state_t st_reg;
	ccmc_state_t st_next;

	// Filter table: rate exponent (7 means kernel clock) and N minus one.
	function automatic logic [5:0] ccmc_filt_cfg(input logic [3:0] code);
		case (code)
			4'h0:    ccmc_filt_cfg = {3'h0, 3'h0};
			4'h1:    ccmc_filt_cfg = {RATE_KERNEL, 3'h1};
			4'h2:    ccmc_filt_cfg = {RATE_KERNEL, 3'h3};
			4'h3:    ccmc_filt_cfg = {RATE_KERNEL, 3'h7};
			4'h4:    ccmc_filt_cfg = {3'h1, 3'h5};
			4'h5:    ccmc_filt_cfg = {3'h1, 3'h7};
			4'h6:    ccmc_filt_cfg = {3'h2, 3'h5};
			4'h7:    ccmc_filt_cfg = {3'h2, 3'h7};
			4'h8:    ccmc_filt_cfg = {3'h3, 3'h5};
			4'h9:    ccmc_filt_cfg = {3'h3, 3'h7};
			4'ha:    ccmc_filt_cfg = {3'h4, 3'h4};
			4'hb:    ccmc_filt_cfg = {3'h4, 3'h7};
			4'hc:    ccmc_filt_cfg = {3'h4, 3'h7};
			4'hd:    ccmc_filt_cfg = {3'h5, 3'h4};
			4'he:    ccmc_filt_cfg = {3'h5, 3'h5};
			default: ccmc_filt_cfg = {3'h5, 3'h7};
		endcase
	endfunction : ccmc_filt_cfg

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// The whole block is one combinational step so that the channel loop
	// can see bus writes, filters and compare logic in a single place.
	always_comb begin
		logic [7:0]           sl;
		logic [7:0]           wm;
		logic [15:0]          wmask;
		logic                 hit;
		logic                 raw;
		logic                 smp;
		logic [5:0]           cfg;
		logic [DTS_DIV_W-1:0] msk;
		logic                 pwmL;
		logic                 match;
		logic [2:0]           pscTop;
		sl     = 8'h00;
		wm     = 8'h00;
		wmask  = 16'h0000;
		raw    = 1'b0;
		smp    = 1'b0;
		cfg    = 6'h00;
		msk    = '0;
		pwmL   = 1'b0;
		match  = 1'b0;
		pscTop = 3'h0;
		hit    = (apbReq.paddr[ADDR_W-1:2] == MODE_REG_OFFSET[ADDR_W-1:2]);
		st_next = st_reg;
		st_next.cap = 2'b00;
		st_next.trigPipe = {st_reg.trigPipe[TRIG_PIPE_LEN-2:0], trigEdge};
		if (dtsTick) begin
			st_next.dtsDiv = st_reg.dtsDiv + 1'b1;
		end

		// Write masks per channel slice.
		for (int i = 0; i < 2; i++) begin
			sl = st_reg.mode[i*CH_STRIDE +: CH_STRIDE];
			wm = 8'hff;
			if (chEnable[i]) begin
				wm[SEL_LSB +: 2] = 2'b00;
			end
			if (lockLevel3 && sl[SEL_LSB +: 2] == SEL_OUTPUT) begin
				wm[MODE_LSB +: 3] = 3'b000;
				wm[PE_BIT] = 1'b0;
			end
			wmask[i*CH_STRIDE +: CH_STRIDE] = wm;
		end

		// Bus slave: answer one cycle after the access phase begins.
		case (st_reg.apb)
			APB_IDLE: begin
				if (apbReq.psel && apbReq.penable) begin
					st_next.apb = APB_ACK;
					st_next.rsp.pready = 1'b1;
					st_next.rsp.pslverr = !hit;
					st_next.rsp.prdata = hit ? {RSVD_READ, st_reg.mode} : 32'h0000_0000;
				end
			end
			APB_ACK: begin
				st_next.apb = APB_IDLE;
				st_next.rsp.pready = 1'b0;
				st_next.rsp.pslverr = 1'b0;
				if (apbReq.pwrite && hit) begin
					st_next.mode = (st_reg.mode & ~wmask) | (apbReq.pwdata[15:0] & wmask);
				end
			end
			default: begin
				st_next.apb = APB_IDLE;
				st_next.rsp.pready = 1'b0;
			end
		endcase

		for (int i = 0; i < 2; i++) begin
			sl = st_reg.mode[i*CH_STRIDE +: CH_STRIDE];

			// Input routing.
			case (sl[SEL_LSB +: 2])
				SEL_OWN:   raw = timerIn[i];
				SEL_NEIGH: raw = timerIn[1-i];
				SEL_TRIG:  raw = trigSrc && trigInternal;
				default:   raw = 1'b0;
			endcase

			// Event-counter filter at the selected sampling rate.
			cfg = ccmc_filt_cfg(sl[FLT_LSB +: 4]);
			msk = DTS_DIV_W'((DTS_DIV_W'(1) << cfg[5:3]) - DTS_DIV_W'(1));
			if (cfg[5:3] == RATE_KERNEL) begin
				smp = 1'b1;
			end else begin
				smp = dtsTick && ((st_reg.dtsDiv & msk) == msk);
			end
			if (smp) begin
				if (raw == st_reg.filt[i]) begin
					st_next.fcnt[i] = 3'h0;
				end else if (st_reg.fcnt[i] >= cfg[2:0]) begin
					// A count left over from a longer filter must not delay the new one.
					st_next.filt[i] = raw;
					st_next.fcnt[i] = 3'h0;
				end else begin
					st_next.fcnt[i] = st_reg.fcnt[i] + 3'h1;
				end
			end

			// Capture prescaler on rising edges of the filtered input.
			pscTop = 3'((4'h1 << sl[PSC_LSB +: 2]) - 4'h1);
			if (!chEnable[i]) begin
				st_next.psc[i] = 3'h0;
			end else if (sl[SEL_LSB +: 2] != SEL_OUTPUT && st_next.filt[i] && !st_reg.filt[i]) begin
				if (st_reg.psc[i] == pscTop) begin
					st_next.psc[i] = 3'h0;
					st_next.cap[i] = 1'b1;
				end else begin
					st_next.psc[i] = st_reg.psc[i] + 3'h1;
				end
			end

			// Compare register with optional preload shadow.
			if (cmpWr[i]) begin
				if (sl[PE_BIT]) begin
					st_next.cmpShadow[i] = cmpWdata;
				end else begin
					st_next.cmpAct[i] = cmpWdata;
				end
			end else if (updateEvt && sl[PE_BIT]) begin
				st_next.cmpAct[i] = st_reg.cmpShadow[i];
			end

			// Output reference.
			match = (counterVal == st_reg.cmpAct[i]) && !st_reg.matchPrev[i];
			st_next.matchPrev[i] = (counterVal == st_reg.cmpAct[i]);
			pwmL = countDown ? !(counterVal > st_reg.cmpAct[i]) : (counterVal < st_reg.cmpAct[i]);
			if (sl[MODE_LSB +: 3] == OM_PWM2) begin
				pwmL = !pwmL;
			end
			st_next.pwmPrev[i] = pwmL;
			st_next.modePrev[i] = sl[MODE_LSB +: 3];
			if (sl[SEL_LSB +: 2] != SEL_OUTPUT) begin
				st_next.oref[i] = 1'b0;
			end else begin
				case (sl[MODE_LSB +: 3])
					OM_SET:    if (match) st_next.oref[i] = 1'b1;
					OM_CLEAR:  if (match) st_next.oref[i] = 1'b0;
					OM_TOGGLE: if (match) st_next.oref[i] = !st_reg.oref[i];
					OM_LOW:    st_next.oref[i] = 1'b0;
					OM_HIGH:   st_next.oref[i] = 1'b1;
					OM_PWM1, OM_PWM2: begin
						if (pwmL != st_reg.pwmPrev[i] || st_reg.modePrev[i] == OM_FROZEN) begin
							st_next.oref[i] = pwmL;
						end
						if (sl[FE_BIT] && st_reg.trigPipe[TRIG_PIPE_LEN-1]) begin
							st_next.oref[i] = (sl[MODE_LSB +: 3] == OM_PWM1);
						end
					end
					default:   st_next.oref[i] = st_reg.oref[i];
				endcase
				if (sl[CE_BIT] && etrFiltered) begin
					st_next.oref[i] = 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset loads constants only; the clock enable freezes everything.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.apb <= APB_IDLE;
			st_reg.mode <= MODE_REG_RESET;
		end else if (clkEn) begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state register.
	assign apbRsp     = st_reg.rsp;
	assign outRef     = st_reg.oref;
	assign capStrobe  = st_reg.cap;
	assign inputLevel = st_reg.filt;
	assign activeCmp  = st_reg.cmpAct;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	logic wrCommit;
	assign wrCommit = clkEn && st_reg.apb == APB_ACK && apbReq.pwrite
		&& apbReq.paddr[ADDR_W-1:2] == MODE_REG_OFFSET[ADDR_W-1:2];

	a_sel_locked: assert property (
		wrCommit && chEnable[0] |=> st_reg.mode[1:0] == $past(st_reg.mode[1:0]))
		else $error("select field changed while channel enabled");
	a_mode_lock: assert property (
		wrCommit && lockLevel3 && st_reg.mode[1:0] == SEL_OUTPUT
		|=> st_reg.mode[6:3] == $past(st_reg.mode[6:3]))
		else $error("mode or preload changed under lock");
	a_force_low: assert property (
		clkEn && st_reg.mode[1:0] == SEL_OUTPUT && st_reg.mode[6:4] == OM_LOW |=> !outRef[0])
		else $error("forced low reference is high");
	a_force_high: assert property (
		clkEn && st_reg.mode[1:0] == SEL_OUTPUT && st_reg.mode[6:4] == OM_HIGH
		&& !(st_reg.mode[7] && etrFiltered) |=> outRef[0])
		else $error("forced high reference is low");
	a_clear_ref: assert property (
		clkEn && st_reg.mode[7] && etrFiltered |=> !outRef[0])
		else $error("reference not cleared by external trigger");
	a_psc_reset: assert property (
		clkEn && !chEnable[1] |=> st_reg.psc[1] == 3'h0)
		else $error("prescaler count kept while disabled");
	a_cap_gate: assert property (
		$rose(capStrobe[0]) |-> $past(chEnable[0]) && $past(st_reg.mode[1:0]) != SEL_OUTPUT)
		else $error("capture issued while disabled or output");
	a_preload_upd: assert property (
		clkEn && updateEvt && st_reg.mode[3] && !cmpWr[0]
		|=> activeCmp[0] == $past(st_reg.cmpShadow[0]))
		else $error("shadow not transferred at update");
	a_direct_cmp: assert property (
		clkEn && cmpWr[0] && !st_reg.mode[3] |=> activeCmp[0] == $past(cmpWdata))
		else $error("direct compare write not taken");
	a_rsvd_zero: assert property (
		apbRsp.pready |-> apbRsp.prdata[31:16] == 16'h0000)
		else $error("reserved bits read nonzero");
	a_fast_trig: assert property (
		clkEn && trigEdge && st_reg.mode[1:0] == SEL_OUTPUT && st_reg.mode[6:4] == OM_PWM1
		&& st_reg.mode[2] && !st_reg.mode[7] ##1 (clkEn && st_reg.mode[6:2] == $past(st_reg.mode[6:2]))[*2]
		|=> outRef[0])
		else $error("fast trigger did not act in three cycles");

	c_capture: cover property (capStrobe[0]);
	c_pwm_edge: cover property (st_reg.mode[6:4] == OM_PWM1 && $rose(outRef[0]));
	c_write: cover property (wrCommit);

endmodule : ccmc_channel_mode

`default_nettype wire

// *** dv/ccmc_channel_mode_tb_top.sv ***
// Self-checking testbench for the two-channel mode control block.
`timescale 1ns/1ps
`default_nettype none

module ccmc_channel_mode_tb_top
	import ccmc_pkg::*;
;
	// ----------------------------------------------------------------
	// Stimulus, observed outputs and bookkeeping
	// ----------------------------------------------------------------
	logic             core_clk = 1'b0;
	logic             nrst = 1'b0;
	ccmc_apb_req_t    apbReq = '0;
	ccmc_apb_rsp_t    apbRsp;
	logic             etrFiltered = 1'b0, trigEdge = 1'b0, lockLevel3 = 1'b0;
	logic             dtsTick = 1'b1, countDown = 1'b0, updateEvt = 1'b0;
	logic             trigSrc = 1'b0, trigInternal = 1'b0;
	logic [1:0]       timerIn = 2'b00, chEnable = 2'b00, cmpWr = 2'b00;
	logic [15:0]      counterVal = 16'h0005, cmpWdata = 16'h0000;
	logic [1:0]       outRef, capStrobe, inputLevel;
	logic [1:0][15:0] activeCmp;
	int               capCnt [2] = '{0, 0};
	int               nFail = 0, testsRun = 0;
	// Match-mode sequence and the reference level expected after each match.
	logic [2:0]       mSeq [5] = '{OM_SET, OM_CLEAR, OM_TOGGLE, OM_FROZEN, OM_TOGGLE};
	logic [4:0]       mExp = 5'b01101;
	// PWM cases: count, direction (bit i) and the mode 1 level (bit i).
	logic [15:0]      pCnt [6] = '{16'h0005, 16'h0020, 16'h0030, 16'h0030, 16'h0020, 16'h0005};
	logic [5:0]       pDir = 6'b111000, pExp = 6'b110001;

	// Kernel clock at 100 MHz.
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// The clock enable is held high for the whole run.
	ccmc_channel_mode #(.CNT_W(16)) i_ccmc_channel_mode (
		.core_clk(core_clk), .nrst(nrst), .clkEn(1'b1), .apbReq(apbReq), .apbRsp(apbRsp),
		.timerIn(timerIn), .trigSrc(trigSrc), .trigInternal(trigInternal),
		.etrFiltered(etrFiltered),
		.trigEdge(trigEdge), .chEnable(chEnable), .lockLevel3(lockLevel3), .dtsTick(dtsTick),
		.counterVal(counterVal), .countDown(countDown), .updateEvt(updateEvt), .cmpWr(cmpWr),
		.cmpWdata(cmpWdata), .outRef(outRef), .capStrobe(capStrobe), .inputLevel(inputLevel),
		.activeCmp(activeCmp)
	);

	// Capture pulses are tallied so that tests compare differences.
	always @(posedge core_clk) begin
		if (capStrobe[0] === 1'b1) capCnt[0] <= capCnt[0] + 1;
		if (capStrobe[1] === 1'b1) capCnt[1] <= capCnt[1] + 1;
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer; the request holds until pready is seen at a rising edge.
	task automatic apb(input string nm, input logic wr, input logic [11:0] a,
			input logic [31:0] d, input logic [31:0] expRd, input logic expErr);
		int n;
		n = 0;
		apbReq.psel <= 1'b1;
		apbReq.penable <= 1'b0;
		apbReq.pwrite <= wr;
		apbReq.paddr <= a;
		apbReq.pwdata <= d;
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 20);
		chk({nm, " ready"}, 32'h1, {31'h0, apbRsp.pready});
		if (!wr) chk(nm, expRd, apbRsp.prdata);
		chk({nm, " slverr"}, {31'h0, expErr}, {31'h0, apbRsp.pslverr});
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task automatic wreg(input logic [31:0] d);
		apb("write", 1'b1, MODE_REG_OFFSET, d, 32'h0, 1'b0);
	endtask : wreg

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	// References are read three edges after the cause, leaving room for the register stage.
	task automatic refIs(input string nm, input logic [1:0] e);
		cyc(3);
		chk(nm, {30'h0, e}, {30'h0, outRef});
	endtask : refIs

	task automatic cmpWrite(input logic [15:0] v);
		cmpWr <= 2'b01;
		cmpWdata <= v;
		cyc(1);
		cmpWr <= 2'b00;
		cyc(1);
	endtask : cmpWrite

	task automatic trig();
		trigEdge <= 1'b1;
		cyc(1);
		trigEdge <= 1'b0;
	endtask : trig

	// Rising edges on timer input one, three cycles high and three low.
	task automatic pulses(input int n);
		repeat (n) begin
			timerIn <= 2'b01;
			cyc(3);
			timerIn <= 2'b00;
			cyc(3);
		end
	endtask : pulses

	task automatic testDone();
		$display("Comparisons %0d, mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : testDone

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		int c0;
		int c1;
		cyc(20);
		nrst <= 1'b1;
		cyc(1);
		// Reset value, an unmapped word, reserved bits and the field layout.
		apb("reset", 1'b0, MODE_REG_OFFSET, 32'h0, 32'h0, 1'b0);
		apb("unmapped", 1'b0, 12'h01c, 32'h0, 32'h0, 1'b1);
		wreg(32'hffffffff);
		apb("fields", 1'b0, MODE_REG_OFFSET, 32'h0, 32'h0000ffff, 1'b0);
		// Select bits hold while the channels are enabled.
		chEnable <= 2'b11;
		wreg(32'h0);
		apb("sel held", 1'b0, MODE_REG_OFFSET, 32'h0, 32'h00000303, 1'b0);
		// Lock level 3 on output channels freezes mode and preload only.
		chEnable <= 2'b00;
		wreg(32'h0);
		lockLevel3 <= 1'b1;
		wreg(32'h0000ffff);
		apb("locked", 1'b0, MODE_REG_OFFSET, 32'h0, 32'h00008787, 1'b0);
		lockLevel3 <= 1'b0;
		wreg(32'h0);
		// Compare value: immediate without preload, shadowed with it.
		cmpWrite(16'h0010);
		chk("cmp direct", 32'h10, {16'h0, activeCmp[0]});
		wreg(32'h00000008);
		cmpWrite(16'h0020);
		chk("cmp shadow", 32'h10, {16'h0, activeCmp[0]});
		updateEvt <= 1'b1;
		cyc(1);
		updateEvt <= 1'b0;
		cyc(1);
		chk("cmp update", 32'h20, {16'h0, activeCmp[0]});
		// Forced levels on both channels, then match-driven modes on channel 1.
		wreg(32'h00005050);
		refIs("forced high", 2'b11);
		wreg(32'h00004040);
		refIs("forced low", 2'b00);
		for (int i = 0; i < 5; i++) begin
			wreg({24'h0, 1'b0, mSeq[i], 4'h0});
			counterVal <= 16'h0020;
			cyc(1);
			counterVal <= 16'h0005;
			refIs("match mode", {1'b0, mExp[i]});
		end
		// Leaving toggle for PWM keeps the level; leaving frozen applies the comparison.
		wreg(32'h00000068);
		refIs("pwm held", 2'b00);
		wreg(32'h00000008);
		// Both PWM modes counting up and down, equal count included, preload on.
		for (int i = 0; i < 12; i++) begin
			countDown <= pDir[i % 6];
			counterVal <= pCnt[i % 6];
			wreg({24'h0, 1'b0, (i < 6) ? OM_PWM1 : OM_PWM2, 4'h8});
			refIs("pwm level", {1'b0, pExp[i % 6] ^ (i >= 6)});
		end
		countDown <= 1'b0;
		// External trigger clear over a forced-high reference.
		wreg(32'h000000d0);
		refIs("clear idle", 2'b01);
		etrFiltered <= 1'b1;
		refIs("clear on", 2'b00);
		wreg(32'h00000050);
		refIs("clear off", 2'b01);
		etrFiltered <= 1'b0;
		// Fast trigger acts as a match after three edges in PWM mode 1, not in set mode.
		counterVal <= 16'h0030;
		wreg(32'h00000000);
		wreg(32'h0000006c);
		refIs("fast idle", 2'b00);
		trig();
		cyc(2);
		chk("fast early", 32'h0, {30'h0, outRef});
		cyc(1);
		chk("fast taken", 32'h1, {30'h0, outRef});
		wreg(32'h00000040);
		wreg(32'h00000014);
		trig();
		refIs("fast ignored", 2'b00);
		// Filter: glitch rejected at N 2, slow count at N 6, code 0 samples on ticks only.
		counterVal <= 16'h0005;
		wreg(32'h00000011);
		timerIn <= 2'b01;
		cyc(1);
		timerIn <= 2'b00;
		cyc(6);
		chk("glitch", 32'h0, {31'h0, inputLevel[0]});
		timerIn <= 2'b01;
		cyc(8);
		chk("n2 level", 32'h1, {31'h0, inputLevel[0]});
		wreg(32'h00000041);
		timerIn <= 2'b00;
		cyc(40);
		timerIn <= 2'b01;
		cyc(8);
		chk("n6 early", 32'h0, {31'h0, inputLevel[0]});
		cyc(20);
		chk("n6 level", 32'h1, {31'h0, inputLevel[0]});
		wreg(32'h00000001);
		dtsTick <= 1'b0;
		timerIn <= 2'b00;
		cyc(6);
		chk("no tick", 32'h1, {31'h0, inputLevel[0]});
		dtsTick <= 1'b1;
		cyc(4);
		chk("tick", 32'h0, {31'h0, inputLevel[0]});
		// Select 11 follows the internal trigger only while an internal input is chosen.
		wreg(32'h00000003);
		trigSrc <= 1'b1;
		cyc(4);
		chk("trig gated", 32'h0, {31'h0, inputLevel[0]});
		trigInternal <= 1'b1;
		cyc(4);
		chk("trig routed", 32'h1, {31'h0, inputLevel[0]});
		trigSrc <= 1'b0;
		trigInternal <= 1'b0;
		cyc(2);
		// Prescaler ratios: channel 1 on its own input, channel 2 on input one.
		for (int p = 0; p < 4; p++) begin
			chEnable <= 2'b00;
			wreg({16'h0, 4'h0, p[1:0], 2'b10, 4'h0, p[1:0], 2'b01});
			chEnable <= 2'b11;
			c0 = capCnt[0];
			c1 = capCnt[1];
			pulses(8);
			chk("ch1 captures", 32'(8 >> p), 32'(capCnt[0] - c0));
			chk("ch2 captures", 32'(8 >> p), 32'(capCnt[1] - c1));
		end
		// Five events, disable, five more at ratio 8: a kept count would capture once.
		c0 = capCnt[0];
		pulses(5);
		chEnable <= 2'b00;
		cyc(2);
		chEnable <= 2'b11;
		pulses(5);
		chk("psc cleared", 32'h0, 32'(capCnt[0] - c0));
		// A disabled input channel issues no capture even at ratio 1.
		chEnable <= 2'b00;
		wreg(32'h00000001);
		c0 = capCnt[0];
		pulses(2);
		chk("capture off", 32'h0, 32'(capCnt[0] - c0));
		testDone();
	end

	// A hang ends the run as a failure; the sequence needs about 700 cycles.
	initial begin
		#200000;
		nFail++;
		testDone();
	end
endmodule : ccmc_channel_mode_tb_top

`default_nettype wire
